// ==== nvm_array_model.sv ====
// Behavioural Flash, EEPROM and configuration arrays behind the controller's command port.
`timescale 1ns/1ps
module nvm_array_model
  import nvm_self_access_pkg::*;
#(
  parameter logic [13:0] DevId = 14'h2D4B // Arbitrary identification value.
) (
  input wire logic core_clk, // Core clock.
  input mem_cmd_t memCmd, // Command from the controller.
  output logic [13:0] memRdata // Array word.
);
  logic [13:0] flash [256];
  logic [13:0] ee [256];
  logic [13:0] cfg [256];
  logic [13:0] lat [256];
  logic [255:0] latV;
  logic [7:0] a;
  logic [13:0] junk;
  logic [13:0] word;
  assign a = memCmd.addr[7:0];
  assign word = (memCmd.space == SPACE_EEPROM) ? ee[a] :
                (memCmd.space == SPACE_FLASH) ? flash[a] : cfg[a];
  // The controller samples the word in the cycle of its read command; otherwise it toggles.
  assign memRdata = ((memCmd.req === 1'b1) && (memCmd.op == OP_READ)) ? word : junk;
  task automatic put(input logic [7:0] i, input logic [13:0] v);
    if (memCmd.space == SPACE_CONFIG) begin
      cfg[i] = v;
    end else begin
      flash[i] = v;
    end
  endtask
  initial begin
    junk = 14'h0000;
    latV = '0;
    for (int i = 0; i < 256; i++) begin
      flash[i] = 14'h0000;
      ee[i] = 14'h0000;
      cfg[i] = 14'h2AAA;
    end
    cfg[6] = DevId;
  end
  // Stale data toggles every cycle, so it is never mistaken for fresh.
  always @(posedge core_clk) begin
    junk <= ~junk;
    if (memCmd.req === 1'b1) begin
      case (memCmd.op)
        OP_LATCH: begin
          lat[a] = memCmd.wdata;
          latV[a] = 1'b1;
        end
        OP_LATCH_PROGRAM: begin
          for (int i = 0; i < 256; i++) begin
            if (latV[i]) begin
              put(8'(i), lat[i]);
            end
          end
          put(a, memCmd.wdata);
          latV = '0;
        end
        OP_ERASE: put(a, 14'h3FFF);
        OP_EE_ERASE_WRITE: ee[a] = {6'h00, memCmd.wdata[7:0]};
        default: ;
      endcase
    end
  end
endmodule

// ==== nvm_self_access_control.sv ====
// Self-access controller for program Flash, data EEPROM and configuration words.
//
// Summary of operation
// RULE_01 - Config-select bit redirects accesses to configuration region.
// RULE_02 - Config region is address bit 15 set, partial.
// RULE_03 - User IDs writable; device ID, config words not.
// RULE_04 - Reading a forbidden config address zeroes data pair.
// RULE_05 - Low data holds EEPROM byte or word bits 7-0.
// RULE_06 - High data holds word bits 13-8; top reads zero.
// RULE_07 - Low address gives bits 7-0, resets zero.
// RULE_08 - High address gives bits 14-8, resets zero.
// RULE_09 - Memory select: one Flash, zero EEPROM, resets zero.
// RULE_10 - Latch-only write trigger just loads latches.
// RULE_11 - Otherwise write trigger latches then programs latched data.
// RULE_12 - Erase-select makes trigger erase; hardware clears it after.
// RULE_13 - EEPROM ignores latch/erase bits; erase then write byte.
// RULE_14 - Error flag set on any write trigger attempt.
// RULE_15 - Enable bit low inhibits all program and erase.
// RULE_16 - Write trigger self-timed, hardware cleared, software-set only.
// RULE_17 - Read trigger loads data pair in one cycle.
// RULE_18 - Software rewrites rows by read, erase, reload, program.
// RULE_19 - Software may verify writes by reading back.
// RULE_20 - Write 55h then AAh before setting write trigger.
// RULE_21 - Core stalls during real program/erase, not latch loads.
// RULE_22 - Unlocked-less or disabled trigger starts no operation.
// RULE_23 - Writes to read-only config addresses change nothing.
//
// Chosen here: the Avalon-MM register port and the address map.
`timescale 1ns/1ps

module nvm_self_access_control
  import nvm_self_access_pkg::*;
#(
  parameter int unsigned ProgCycles = PROG_CYCLES
) (
  input wire logic core_clk, // Core clock, 100 MHz.
  input wire logic rst, // Asynchronous reset, active high.
  input wire logic [4:0] avs_address, // Byte address of the register.
  input wire logic avs_read, // Read request.
  input wire logic avs_write, // Write request.
  input wire logic [31:0] avs_writedata, // Write data, low byte used.
  input wire logic [3:0] avs_byteenable, // Byte lane enables.
  output logic [31:0] avs_readdata, // Read data.
  output logic avs_waitrequest, // Stall of the current request.
  output mem_cmd_t memCmd, // Command to the memory arrays.
  input wire logic [13:0] memRdata, // Array word, valid in the cycle that the read command stands.
  output logic cpuStall // Core execution stall during program/erase.
);

  if (ProgCycles < 1) begin : gen_check
    $error("ProgCycles must be at least one");
  end

  nvm_state_t cur_ff;
  nvm_state_t nxt_state;

  logic busReq;
  logic access;
  logic wrAcc;
  logic [7:0] wByte;
  logic [14:0] wordAddr;
  mem_space_t target;

  // Configuration addresses that may be read.
  function automatic logic cfgReadable(input logic [14:0] a);
    cfgReadable = (a <= CFG_USER_ID_LAST) || (a == CFG_DEVICE_ID) ||
                  ((a >= CFG_WORD_FIRST) && (a <= CFG_WORD_LAST));
  endfunction

  // Configuration addresses that may be written.
  function automatic logic cfgWritable(input logic [14:0] a);
    cfgWritable = (a <= CFG_USER_ID_LAST);
  endfunction

  assign busReq = avs_read || avs_write;
  assign access = busReq && cur_ff.ack;
  assign wrAcc = access && avs_write && avs_byteenable[0];
  assign wByte = avs_writedata[7:0];
  assign wordAddr = {cur_ff.addrHigh, cur_ff.addrLow}; // [RULE_07] [RULE_08]

  always_comb begin
    if (cur_ff.ctrl.configSpaceSelect) begin
      target = SPACE_CONFIG; // [RULE_01] [RULE_02]
    end else if (cur_ff.ctrl.flashOrEepromSelect) begin
      target = SPACE_FLASH; // [RULE_09]
    end else begin
      target = SPACE_EEPROM;
    end
  end

  always_comb begin
    nxt_state = cur_ff;
    nxt_state.cmd.req = 1'b0;
    nxt_state.ack = busReq && !cur_ff.ack;

    // Sequencer: triggers are served one at a time from idle.
    unique case (cur_ff.st)
      ST_IDLE: begin
        if (cur_ff.ctrl.writeTrigger) begin
          nxt_state.cmd.space = target;
          nxt_state.cmd.addr = wordAddr;
          nxt_state.cmd.wdata = {cur_ff.dataHigh, cur_ff.dataLow};
          if (target == SPACE_EEPROM) begin
            nxt_state.cmd.req = 1'b1;
            nxt_state.cmd.op = OP_EE_ERASE_WRITE; // [RULE_13]
            nxt_state.timer = ProgCycles - 32'd1;
            nxt_state.stall = 1'b1; // [RULE_21]
            nxt_state.st = ST_PROG;
          end else if ((target == SPACE_CONFIG) && !cfgWritable(wordAddr)) begin
            nxt_state.ctrl.writeTrigger = 1'b0; // [RULE_23] [RULE_03]
            nxt_state.ctrl.sequenceErrorFlag = 1'b0;
          end else if (cur_ff.ctrl.eraseSelect) begin
            nxt_state.cmd.req = 1'b1;
            nxt_state.cmd.op = OP_ERASE; // [RULE_12]
            nxt_state.timer = ProgCycles - 32'd1;
            nxt_state.stall = 1'b1; // [RULE_21]
            nxt_state.st = ST_PROG;
          end else if (cur_ff.ctrl.latchOnlyMode) begin
            nxt_state.cmd.req = 1'b1;
            nxt_state.cmd.op = OP_LATCH; // [RULE_10]
            nxt_state.ctrl.writeTrigger = 1'b0;
            nxt_state.ctrl.sequenceErrorFlag = 1'b0;
          end else begin
            nxt_state.cmd.req = 1'b1;
            nxt_state.cmd.op = OP_LATCH_PROGRAM; // [RULE_11]
            nxt_state.timer = ProgCycles - 32'd1;
            nxt_state.stall = 1'b1; // [RULE_21]
            nxt_state.st = ST_PROG;
          end
        end else if (cur_ff.ctrl.readTrigger) begin
          if ((target == SPACE_CONFIG) && !cfgReadable(wordAddr)) begin
            nxt_state.dataLow = 8'h00; // [RULE_04]
            nxt_state.dataHigh = 6'h00;
            nxt_state.ctrl.readTrigger = 1'b0;
          end else begin
            nxt_state.cmd.req = 1'b1;
            nxt_state.cmd.op = OP_READ;
            nxt_state.cmd.space = target;
            nxt_state.cmd.addr = wordAddr;
            nxt_state.st = ST_READ;
          end
        end
      end
      ST_READ: begin
        nxt_state.dataLow = memRdata[7:0]; // [RULE_05] [RULE_17]
        if (cur_ff.cmd.space != SPACE_EEPROM) begin
          nxt_state.dataHigh = memRdata[13:8]; // [RULE_06]
        end
        nxt_state.ctrl.readTrigger = 1'b0; // [RULE_17]
        nxt_state.st = ST_IDLE;
      end
      ST_PROG: begin
        if (cur_ff.timer == 32'd0) begin
          nxt_state.ctrl.writeTrigger = 1'b0; // [RULE_16]
          nxt_state.ctrl.sequenceErrorFlag = 1'b0;
          nxt_state.stall = 1'b0;
          if (cur_ff.cmd.op == OP_ERASE) begin
            nxt_state.ctrl.eraseSelect = 1'b0; // [RULE_12]
          end
          nxt_state.st = ST_IDLE;
        end else begin
          nxt_state.timer = cur_ff.timer - 32'd1;
        end
      end
    endcase

    // Read data is prepared in the first cycle and stands at the accepting edge.
    if (busReq && !cur_ff.ack) begin
      unique case (avs_address)
        OFS_DATA_LOW: nxt_state.rdata = {24'h000000, cur_ff.dataLow};
        OFS_DATA_HIGH: nxt_state.rdata = {26'h0000000, cur_ff.dataHigh}; // [RULE_06]
        OFS_ADDR_LOW: nxt_state.rdata = {24'h000000, cur_ff.addrLow};
        OFS_ADDR_HIGH: nxt_state.rdata = {25'h0000000, cur_ff.addrHigh}; // [RULE_08]
        OFS_CONTROL: nxt_state.rdata = {24'h000000, cur_ff.ctrl};
        default: nxt_state.rdata = 32'h00000000;
      endcase
    end

    // Bus writes come last so that a software set beats a hardware clear; the write trigger can only be set when idle and not already set.
    if (wrAcc) begin
      if (avs_address == OFS_UNLOCK) begin
        if (wByte == UNLOCK_FIRST) begin
          nxt_state.unlockStep = 1'b1; // [RULE_20]
          nxt_state.unlockArmed = 1'b0;
        end else begin
          nxt_state.unlockArmed = cur_ff.unlockStep && (wByte == UNLOCK_SECOND); // [RULE_20]
          nxt_state.unlockStep = 1'b0;
        end
      end else begin
        nxt_state.unlockStep = 1'b0;
        nxt_state.unlockArmed = 1'b0;
      end
      unique case (avs_address)
        OFS_DATA_LOW: nxt_state.dataLow = wByte; // [RULE_05]
        OFS_DATA_HIGH: nxt_state.dataHigh = wByte[5:0]; // [RULE_06]
        OFS_ADDR_LOW: nxt_state.addrLow = wByte; // [RULE_07]
        OFS_ADDR_HIGH: nxt_state.addrHigh = wByte[6:0]; // [RULE_08]
        OFS_CONTROL: begin
          nxt_state.ctrl.flashOrEepromSelect = wByte[BIT_SELECT]; // [RULE_09]
          nxt_state.ctrl.configSpaceSelect = wByte[BIT_CONFIG]; // [RULE_01]
          nxt_state.ctrl.latchOnlyMode = wByte[BIT_LATCH_ONLY];
          nxt_state.ctrl.eraseSelect = wByte[BIT_ERASE];
          nxt_state.ctrl.programEraseEnable = wByte[BIT_ENABLE];
          nxt_state.ctrl.sequenceErrorFlag = wByte[BIT_ERROR] || wByte[BIT_WRITE]; // [RULE_14]
          if (wByte[BIT_WRITE] && cur_ff.unlockArmed && cur_ff.ctrl.programEraseEnable &&
              (cur_ff.st == ST_IDLE) && !cur_ff.ctrl.writeTrigger) begin
            nxt_state.ctrl.writeTrigger = 1'b1; // [RULE_15] [RULE_22] [RULE_16]
          end
          nxt_state.ctrl.readTrigger = nxt_state.ctrl.readTrigger || wByte[BIT_READ]; // [RULE_17]
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cur_ff <= '{st: ST_IDLE, dataLow: DATA_LOW_RESET, dataHigh: DATA_HIGH_RESET,
                  addrLow: ADDR_LOW_RESET, addrHigh: ADDR_HIGH_RESET, ctrl: CTRL_RESET,
                  unlockStep: 1'b0, unlockArmed: 1'b0, timer: 32'd0, stall: 1'b0,
                  cmd: '0, ack: 1'b0, rdata: 32'h00000000};
    end else begin
      cur_ff <= nxt_state;
    end
  end

  assign avs_waitrequest = busReq && !cur_ff.ack;
  assign avs_readdata = cur_ff.rdata;
  assign memCmd = cur_ff.cmd;
  assign cpuStall = cur_ff.stall;

  chk_read_done: assert property (@(posedge core_clk) disable iff (rst) // [RULE_17]
    (cur_ff.st == ST_READ) |=> !cur_ff.ctrl.readTrigger && (cur_ff.st == ST_IDLE))
    else $error("read trigger not cleared after read");

  chk_cfg_read_zero: assert property (@(posedge core_clk) disable iff (rst) // [RULE_04]
    ((cur_ff.st == ST_IDLE) && !cur_ff.ctrl.writeTrigger && cur_ff.ctrl.readTrigger &&
     cur_ff.ctrl.configSpaceSelect && !cfgReadable(wordAddr) && !wrAcc)
    |=> (cur_ff.dataLow == 8'h00) && (cur_ff.dataHigh == 6'h00))
    else $error("forbidden config read did not clear data pair");

  chk_high_zero: assert property (@(posedge core_clk) disable iff (rst) // [RULE_06]
    (cur_ff.ack && (avs_address == OFS_DATA_HIGH)) |-> (avs_readdata[7:6] == 2'b00))
    else $error("unimplemented data high bits read nonzero");

  chk_no_locked_op: assert property (@(posedge core_clk) disable iff (rst) // [RULE_22]
    $rose(cur_ff.ctrl.writeTrigger) |-> $past(cur_ff.unlockArmed) &&
                                         $past(cur_ff.ctrl.programEraseEnable))
    else $error("write started without unlock or enable");

  chk_latch_no_stall: assert property (@(posedge core_clk) disable iff (rst) // [RULE_10]
    (memCmd.req && (memCmd.op == OP_LATCH)) |-> !cpuStall ##1 !cpuStall)
    else $error("latch load stalled the core");

  chk_stall_hold: assert property (@(posedge core_clk) disable iff (rst) // [RULE_21]
    ((cur_ff.st == ST_PROG) && (cur_ff.timer != 32'd0)) |-> cpuStall ##1 cpuStall)
    else $error("stall dropped before program finished");

  chk_erase_clear: assert property (@(posedge core_clk) disable iff (rst) // [RULE_12]
    ((cur_ff.st == ST_PROG) && (cur_ff.timer == 32'd0) && (memCmd.op == OP_ERASE) && !wrAcc)
    |=> !cur_ff.ctrl.eraseSelect && !cur_ff.ctrl.writeTrigger)
    else $error("erase select not cleared after erase");

  chk_err_on_wr: assert property (@(posedge core_clk) disable iff (rst) // [RULE_14]
    (wrAcc && (avs_address == OFS_CONTROL) && avs_writedata[BIT_WRITE])
    |=> cur_ff.ctrl.sequenceErrorFlag)
    else $error("write trigger attempt did not set error flag");

  chk_ee_op: assert property (@(posedge core_clk) disable iff (rst) // [RULE_13]
    (memCmd.req && (memCmd.space == SPACE_EEPROM) && (memCmd.op != OP_READ))
    |-> (memCmd.op == OP_EE_ERASE_WRITE) && cpuStall)
    else $error("EEPROM write was not an erase-write cycle");

  chk_ro_config: assert property (@(posedge core_clk) disable iff (rst) // [RULE_23]
    (memCmd.req && (memCmd.space == SPACE_CONFIG) && (memCmd.op != OP_READ))
    |-> (memCmd.addr <= CFG_USER_ID_LAST))
    else $error("write issued to read-only config address");

  chk_enable_gate: assert property (@(posedge core_clk) disable iff (rst) // [RULE_15]
    (wrAcc && (avs_address == OFS_CONTROL) && !cur_ff.ctrl.programEraseEnable &&
     !cur_ff.ctrl.writeTrigger) |=> !cur_ff.ctrl.writeTrigger)
    else $error("write trigger set while writes disabled");

endmodule

// ==== nvm_self_access_control_tb.sv ====
// Self-checking bench for the nonvolatile self-access controller.
`timescale 1ns/1ps
module nvm_self_access_control_tb
  import nvm_self_access_pkg::*;
;
  localparam logic [13:0] DEV_ID = 14'h2D4B; // Arbitrary identification value.
  logic core_clk;
  logic rst;
  logic avs_read;
  logic avs_write;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic cpuStall;
  logic [13:0] memRdata;
  mem_cmd_t memCmd;
  int bad_count = 0;
  int check_count = 0;
  int stallCount = 0;
  nvm_self_access_control #(.ProgCycles(10)) i_nvm_self_access_control (
    .core_clk(core_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'h1),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .memCmd(memCmd),
    .memRdata(memRdata), .cpuStall(cpuStall));
  nvm_array_model #(.DevId(DEV_ID)) i_nvm_array_model (
    .core_clk(core_clk), .memCmd(memCmd), .memRdata(memRdata));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) if (cpuStall === 1'b1) stallCount++;
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // One bus transfer; the request stands until waitrequest is seen low at an edge.
  task automatic bus(input bit w, input logic [4:0] a, input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (n >= 20) bad_count++;
    q = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    check(q, e);
  endtask
  task automatic ld(input logic [7:0] a, input logic [7:0] lo, input logic [7:0] hi);
    wr(OFS_ADDR_LOW, a);
    wr(OFS_DATA_LOW, lo);
    wr(OFS_DATA_HIGH, hi);
  endtask
  // Polls the control register until the given trigger bit has been cleared by hardware.
  task automatic settle(input int b);
    logic [7:0] q;
    int n;
    n = 0;
    do begin
      bus(1'b0, OFS_CONTROL, 8'h00, q);
      n++;
    end while (q[b] !== 1'b0 && n < 50);
    if (n >= 50) bad_count++;
  endtask
  // The enable bit must already stand before the unlock pair and the trigger.
  task automatic go(input logic [7:0] c);
    wr(OFS_CONTROL, c & 8'hFD);
    wr(OFS_UNLOCK, UNLOCK_FIRST);
    wr(OFS_UNLOCK, UNLOCK_SECOND);
    stallCount = 0;
    wr(OFS_CONTROL, c);
    settle(BIT_WRITE);
  endtask
  task automatic rb(input logic [7:0] c, input logic [7:0] a, input logic [7:0] h,
                    input logic [7:0] lo, input logic [7:0] hi);
    ld(a, 8'hA5, h);
    wr(OFS_CONTROL, c | 8'h01);
    settle(BIT_READ);
    rd(OFS_DATA_LOW, lo);
    rd(OFS_DATA_HIGH, hi);
  endtask
  initial begin
    rst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 5'h00;
    avs_writedata = 32'h00000000;
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    rd(OFS_CONTROL, 8'h00);
    rd(OFS_ADDR_LOW, 8'h00);
    rd(OFS_ADDR_HIGH, 8'h00);
    wr(OFS_ADDR_HIGH, 8'hFF);
    rd(OFS_ADDR_HIGH, 8'h7F);
    wr(OFS_DATA_HIGH, 8'hFF);
    rd(OFS_DATA_HIGH, 8'h3F);
    rd(5'h18, 8'h00);
    wr(OFS_ADDR_HIGH, 8'h00);
    $display("test registers done");
    ld(8'h13, 8'h77, 8'h01);
    go(8'hA6);
    check(8'(stallCount), 8'h00);
    rd(OFS_CONTROL, 8'hA4);
    rb(8'h80, 8'h13, 8'h00, 8'h00, 8'h00);
    ld(8'h12, 8'h5C, 8'h1A);
    wr(OFS_CONTROL, 8'h84);
    wr(OFS_UNLOCK, UNLOCK_FIRST);
    wr(OFS_UNLOCK, UNLOCK_SECOND);
    stallCount = 0;
    wr(OFS_CONTROL, 8'h86);
    rd(OFS_CONTROL, 8'h8E);
    repeat (20) @(posedge core_clk);
    rd(OFS_CONTROL, 8'h84);
    check(8'(stallCount), 8'h0A);
    rb(8'h80, 8'h12, 8'h00, 8'h5C, 8'h1A);
    rd(OFS_CONTROL, 8'h80);
    rb(8'h80, 8'h13, 8'h00, 8'h77, 8'h01);
    $display("test latch and program done");
    ld(8'h12, 8'h33, 8'h02);
    wr(OFS_CONTROL, 8'h84);
    wr(OFS_CONTROL, 8'h86);
    rd(OFS_CONTROL, 8'h8C);
    wr(OFS_CONTROL, 8'h80);
    wr(OFS_UNLOCK, UNLOCK_FIRST);
    wr(OFS_UNLOCK, UNLOCK_SECOND);
    wr(OFS_CONTROL, 8'h82);
    rd(OFS_CONTROL, 8'h88);
    rb(8'h80, 8'h12, 8'h00, 8'h5C, 8'h1A);
    $display("test refused triggers done");
    go(8'h96);
    rd(OFS_CONTROL, 8'h84);
    check(8'(stallCount), 8'h0A);
    rb(8'h80, 8'h12, 8'h00, 8'hFF, 8'h3F);
    ld(8'h12, 8'h5C, 8'h1A);
    go(8'h86);
    rb(8'h80, 8'h12, 8'h00, 8'h5C, 8'h1A);
    $display("test erase done");
    ld(8'h05, 8'hC3, 8'h00);
    go(8'h36);
    check(8'(stallCount), 8'h0A);
    rb(8'h00, 8'h05, 8'h15, 8'hC3, 8'h15);
    $display("test eeprom done");
    ld(8'h01, 8'h2B, 8'h03);
    go(8'h46);
    rb(8'h40, 8'h01, 8'h00, 8'h2B, 8'h03);
    rb(8'h80, 8'h01, 8'h00, 8'h00, 8'h00);
    ld(8'h06, 8'h11, 8'h11);
    go(8'h46);
    rb(8'h40, 8'h06, 8'h00, DEV_ID[7:0], {2'b00, DEV_ID[13:8]});
    rb(8'h40, 8'h05, 8'h15, 8'h00, 8'h00);
    $display("test configuration done");
    summarize();
  end
  initial begin
    #100us;
    bad_count++;
    summarize();
  end
endmodule

// ==== nvm_self_access_pkg.sv ====
// Constants and carrier types for the nonvolatile self-access controller.
package nvm_self_access_pkg;

  // Clock rate and self-timed program/erase duration.
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned PROG_TIME_US = 2000;
  localparam int unsigned PROG_CYCLES = PROG_TIME_US * CLK_MHZ;

  // Register byte offsets on the Avalon-MM slave.
  localparam logic [4:0] OFS_DATA_LOW = 5'h00;
  localparam logic [4:0] OFS_DATA_HIGH = 5'h04;
  localparam logic [4:0] OFS_ADDR_LOW = 5'h08;
  localparam logic [4:0] OFS_ADDR_HIGH = 5'h0C;
  localparam logic [4:0] OFS_CONTROL = 5'h10;
  localparam logic [4:0] OFS_UNLOCK = 5'h14;

  // Control register bit positions.
  localparam int BIT_SELECT = 7;
  localparam int BIT_CONFIG = 6;
  localparam int BIT_LATCH_ONLY = 5;
  localparam int BIT_ERASE = 4;
  localparam int BIT_ERROR = 3;
  localparam int BIT_ENABLE = 2;
  localparam int BIT_WRITE = 1;
  localparam int BIT_READ = 0;

  // Values after reset.
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] ADDR_LOW_RESET = 8'h00;
  localparam logic [6:0] ADDR_HIGH_RESET = 7'h00;
  localparam logic [7:0] DATA_LOW_RESET = 8'h00;
  localparam logic [5:0] DATA_HIGH_RESET = 6'h00;

  // Unlock sequence keys.
  localparam logic [7:0] UNLOCK_FIRST = 8'h55;
  localparam logic [7:0] UNLOCK_SECOND = 8'hAA;

  // Configuration region offsets (added to the region base with address bit 15 set).
  localparam logic [14:0] CFG_USER_ID_LAST = 15'h0003;
  localparam logic [14:0] CFG_DEVICE_ID = 15'h0006;
  localparam logic [14:0] CFG_WORD_FIRST = 15'h0007;
  localparam logic [14:0] CFG_WORD_LAST = 15'h0008;

  typedef enum logic [1:0] {SPACE_EEPROM, SPACE_FLASH, SPACE_CONFIG} mem_space_t;
  typedef enum logic [2:0] {OP_READ, OP_LATCH, OP_LATCH_PROGRAM, OP_ERASE,
                            OP_EE_ERASE_WRITE} mem_op_t;
  typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_PROG} seq_state_t;

  typedef struct packed {
    logic req;
    mem_op_t op;
    mem_space_t space;
    logic [14:0] addr;
    logic [13:0] wdata;
  } mem_cmd_t;

  typedef struct packed {
    logic flashOrEepromSelect;
    logic configSpaceSelect;
    logic latchOnlyMode;
    logic eraseSelect;
    logic sequenceErrorFlag;
    logic programEraseEnable;
    logic writeTrigger;
    logic readTrigger;
  } ctrl_t;

  typedef struct packed {
    seq_state_t st;
    logic [7:0] dataLow;
    logic [5:0] dataHigh;
    logic [7:0] addrLow;
    logic [6:0] addrHigh;
    ctrl_t ctrl;
    logic unlockStep;
    logic unlockArmed;
    logic [31:0] timer;
    logic stall;
    mem_cmd_t cmd;
    logic ack;
    logic [31:0] rdata;
  } nvm_state_t;

endpackage
